// *** hw/cbrw_pkg.sv ***
// How it works
// [RULE_01] Word 25h: input current 50 mA/step, comparator input 12 mV/step.
// [RULE_02] Word 26h: system, battery voltage, 64 mV/step, 2.88 V to 19.2 V.
// [RULE_03] Word 3Bh holds an 8-bit OTG voltage setpoint, 64 mV/step.
// [RULE_04] Word 3Ch holds a 7-bit OTG current limit, 50 mA/step.
// [RULE_05] Word 3Dh holds an 8-bit input voltage setpoint, 64 mV/step.
// [RULE_06] Word 3Eh: 6-bit minimum system voltage, default set by cell count.
// [RULE_07] Word 3Fh holds a 6-bit host input current limit, 50 mA/step.
// [RULE_08] Option word 12h loads E20Eh on reset.
// [RULE_09] Bit 15 low power, default 1; on battery disables monitors and ADC.
// [RULE_10] Bit 15 clear: on battery, functions follow their own settings.
// [RULE_11] In low power, comparator still runs if bit 14 or 13 of 30h set.
// [RULE_12] No write to 14h or 15h within period forces zero charge current.
// [RULE_13] Writes to 14h, 15h, 12h restart watchdog; valid values resume.
// [RULE_14] Period field 14:13: 00 off, 01 is 5 s, 10 is 88 s.
// [RULE_15] Period field 11 gives 175 seconds and is the reset value.
// [RULE_16] Timeout counts prescaled clock ticks from zero after each restart.
// [RULE_17] Writes to read-only conversion and identity words are ignored.
package cbrw_pkg;
   localparam logic [7:0]  CMD_OPTION0    = 8'h12;
   localparam logic [7:0]  CMD_CHG_CUR    = 8'h14;
   localparam logic [7:0]  CMD_CHG_VOLT   = 8'h15;
   localparam logic [7:0]  CMD_ADC_IINCMP = 8'h25;
   localparam logic [7:0]  CMD_ADC_SYSBAT = 8'h26;
   localparam logic [7:0]  CMD_OTG_VOLT   = 8'h3B;
   localparam logic [7:0]  CMD_OTG_CUR    = 8'h3C;
   localparam logic [7:0]  CMD_IN_VOLT    = 8'h3D;
   localparam logic [7:0]  CMD_MIN_SYS    = 8'h3E;
   localparam logic [7:0]  CMD_HOST_LIMIT = 8'h3F;
   localparam logic [7:0]  CMD_MAKER_ID   = 8'hFE;
   localparam logic [7:0]  CMD_PART_ID    = 8'hFF;

   localparam logic [15:0] OPTION0_RESET  = 16'hE20E;
   localparam int          LWPWR_BIT      = 15;
   localparam int          WDSEL_HI       = 14;
   localparam int          WDSEL_LO       = 13;
   localparam logic [15:0] SETPOINT_RESET = 16'h0000;

   localparam logic [1:0]  WD_OFF         = 2'h0;
   localparam logic [1:0]  WD_5S          = 2'h1;
   localparam logic [1:0]  WD_88S         = 2'h2;
   localparam logic [1:0]  WD_175S        = 2'h3;

   // Minimum system voltage defaults in 256 mV steps, one to four cells.
   localparam logic [5:0]  MINSYS_1S      = 6'h0E;
   localparam logic [5:0]  MINSYS_2S      = 6'h18;
   localparam logic [5:0]  MINSYS_3S      = 6'h24;
   localparam logic [5:0]  MINSYS_4S      = 6'h30;

   localparam int          CLK_MHZ        = 200;
   localparam int          TICK_US        = 1000;
   localparam int          TICK_CYCLES    = TICK_US * CLK_MHZ;
   localparam int          WD_5S_SEC      = 5;
   localparam int          WD_88S_SEC     = 88;
   localparam int          WD_175S_SEC    = 175;
   localparam int          TICKS_PER_SEC  = 1000000 / TICK_US;
   localparam int          WD_5S_TICKS    = WD_5S_SEC * TICKS_PER_SEC;
   localparam int          WD_88S_TICKS   = WD_88S_SEC * TICKS_PER_SEC;
   localparam int          WD_175S_TICKS  = WD_175S_SEC * TICKS_PER_SEC;
endpackage : cbrw_pkg

// *** hw/cbrw_watchdog.sv ***
`timescale 1ns/1ps
module cbrw_watchdog
   import cbrw_pkg::*;
#(
   parameter int TICK_LEN  = TICK_CYCLES,
   parameter int T5_TICKS  = WD_5S_TICKS,
   parameter int T88_TICKS = WD_88S_TICKS,
   parameter int T175_TICKS = WD_175S_TICKS
) (
   input  wire logic       clk,        // Core clock.
   input  wire logic       reset,      // Synchronous reset, active high.
   input  wire logic [1:0] period_sel, // Watchdog period select.
   input  wire logic       restart,    // Qualifying write seen.
   output logic            expired     // Timeout reached, held.
);
   logic [17:0] tick_reg;
   logic [17:0] tick_next;
   logic [17:0] cnt_reg;
   logic [17:0] cnt_next;
   logic        exp_reg;
   logic        exp_next;
   logic [17:0] limit;
   logic        tick_pulse;

   assign expired = exp_reg;

   always_comb begin
      case (period_sel) // RULE_14
         WD_5S:   limit = 18'(T5_TICKS);
         WD_88S:  limit = 18'(T88_TICKS);
         WD_175S: limit = 18'(T175_TICKS); // RULE_15
         default: limit = 18'h00001;
      endcase
      tick_pulse = (tick_reg == 18'(TICK_LEN - 1));
      tick_next  = tick_reg;
      cnt_next   = cnt_reg;
      exp_next   = exp_reg;
      if (restart || period_sel == WD_OFF) begin
         tick_next = 18'h00000; // RULE_16
         cnt_next  = 18'h00000; // RULE_16
         exp_next  = 1'b0; // RULE_13
      end else if (!exp_reg) begin
         tick_next = tick_pulse ? 18'h00000 : tick_reg + 18'h00001; // RULE_16
         if (tick_pulse) begin
            if (cnt_reg == limit - 18'h00001) begin
               cnt_next = 18'h00000;
               exp_next = 1'b1; // RULE_12
            end else begin
               cnt_next = cnt_reg + 18'h00001;
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         tick_reg <= 18'h00000;
         cnt_reg  <= 18'h00000;
         exp_reg  <= 1'b0;
      end else begin
         tick_reg <= tick_next;
         cnt_reg  <= cnt_next;
         exp_reg  <= exp_next;
      end
   end

   AST_RESTART_CLEARS: assert property ( // RULE_13
      @(posedge clk) disable iff (reset)
      restart |=> !expired && tick_reg == 18'h00000)
      else $error("Watchdog did not restart on a qualifying write.");

   AST_EXPIRY_CAUSE: assert property ( // RULE_12
      @(posedge clk) disable iff (reset)
      $rose(expired) |-> $past(tick_pulse)
      && $past(cnt_reg) == $past(limit) - 18'h00001)
      else $error("Watchdog expired before its period ran out.");

   AST_OFF_NEVER: assert property ( // RULE_14
      @(posedge clk) disable iff (reset)
      period_sel == WD_OFF |=> !expired)
      else $error("Disabled watchdog reported expiry.");
endmodule : cbrw_watchdog

// *** hw/cbrw_register_bank.sv ***
`timescale 1ns/1ps
module cbrw_register_bank
   import cbrw_pkg::*;
#(
   parameter int          TICK_LEN   = TICK_CYCLES,
   parameter int          T5_TICKS   = WD_5S_TICKS,
   parameter int          T88_TICKS  = WD_88S_TICKS,
   parameter int          T175_TICKS = WD_175S_TICKS,
   parameter logic [15:0] MAKER_ID   = 16'h0A5A, // Arbitrary value.
   parameter logic [15:0] PART_ID    = 16'h00C3  // Arbitrary value.
) (
   input  wire logic        clk,              // Core clock, 200 MHz.
   input  wire logic        reset,            // Synchronous reset.
   input  wire logic        cmd_valid,        // Word command strobe.
   input  wire logic        cmd_write,        // 1 write, 0 read.
   input  wire logic [7:0]  cmd_code,         // Command code.
   input  wire logic [15:0] cmd_wdata,        // Write word.
   output logic [15:0]      rd_data,          // Read word.
   output logic             rd_valid,         // Read data pulse.
   input  wire logic [1:0]  cell_count,       // Cells minus one.
   input  wire logic [7:0]  adc_input_current,  // Input current code.
   input  wire logic [7:0]  adc_comparator_input, // Comparator code.
   input  wire logic [7:0]  adc_system_voltage, // System voltage code.
   input  wire logic [7:0]  adc_battery_voltage, // Battery voltage code.
   input  wire logic        battery_only,     // Running from battery.
   input  wire logic        cmp_opt_a,        // Bit 14 of word 30h.
   input  wire logic        cmp_opt_b,        // Bit 13 of word 30h.
   input  wire logic        prochot_cfg_en,   // Own setting, prochot.
   input  wire logic        monitor_cfg_en,   // Own setting, buffers.
   input  wire logic        comparator_cfg_en, // Own setting, comparator.
   input  wire logic        adc_cfg_en,       // Own setting, ADC.
   input  wire logic        charge_values_valid, // Charge words valid.
   output logic             prochot_enable,   // Prochot logic on.
   output logic             monitor_enable,   // Monitor buffers on.
   output logic             comparator_enable, // Comparator on.
   output logic             adc_enable,       // ADC on.
   output logic             charge_current_zero, // Force 0 mA.
   output logic             charge_enable,    // Charging allowed.
   output logic [7:0]       otg_voltage,      // OTG voltage code.
   output logic [6:0]       otg_current,      // OTG current code.
   output logic [7:0]       input_voltage,    // Input voltage code.
   output logic [5:0]       min_system_voltage, // Min system code.
   output logic [5:0]       host_input_current_limit, // Host limit.
   output logic [15:0]      charge_option_word_0 // Option word.
);
   logic [15:0] opt_reg;
   logic [15:0] opt_next;
   logic [7:0]  otgv_reg;
   logic [7:0]  otgv_next;
   logic [6:0]  otgc_reg;
   logic [6:0]  otgc_next;
   logic [7:0]  inv_reg;
   logic [7:0]  inv_next;
   logic [5:0]  minsys_reg;
   logic [5:0]  minsys_next;
   logic [5:0]  iinh_reg;
   logic [5:0]  iinh_next;
   logic [15:0] adc_a_reg;
   logic [15:0] adc_a_next;
   logic [15:0] adc_b_reg;
   logic [15:0] adc_b_next;
   logic [15:0] rd_reg;
   logic [15:0] rd_next;
   logic        rdv_reg;
   logic        rdv_next;
   logic        strap_done_reg;
   logic        strap_done_next;
   logic        low_power_enable;
   logic        low_power_active;
   logic        wr;
   logic        wd_restart;
   logic        wd_expired;
   logic [5:0]  strap_value;

   assign wr               = cmd_valid && cmd_write;
   assign low_power_enable = opt_reg[LWPWR_BIT];
   assign low_power_active = low_power_enable && battery_only;
   assign wd_restart       = wr && (cmd_code == CMD_CHG_CUR ||
                             cmd_code == CMD_CHG_VOLT ||
                             cmd_code == CMD_OPTION0); // RULE_13

   cbrw_watchdog #(
      .TICK_LEN   (TICK_LEN),
      .T5_TICKS   (T5_TICKS),
      .T88_TICKS  (T88_TICKS),
      .T175_TICKS (T175_TICKS)
   ) u_watchdog (
      .clk        (clk),
      .reset      (reset),
      .period_sel (opt_reg[WDSEL_HI:WDSEL_LO]), // RULE_14
      .restart    (wd_restart),
      .expired    (wd_expired)
   );

   always_comb begin
      case (cell_count) // RULE_06
         2'h0:    strap_value = MINSYS_1S;
         2'h1:    strap_value = MINSYS_2S;
         2'h2:    strap_value = MINSYS_3S;
         default: strap_value = MINSYS_4S;
      endcase
   end

   // Setpoint and option writes; conversions and identities take none.
   always_comb begin
      opt_next        = opt_reg;
      otgv_next       = otgv_reg;
      otgc_next       = otgc_reg;
      inv_next        = inv_reg;
      minsys_next     = minsys_reg;
      iinh_next       = iinh_reg;
      strap_done_next = 1'b1;
      if (!strap_done_reg) begin
         minsys_next = strap_value; // RULE_06
      end
      if (wr) begin
         case (cmd_code)
            CMD_OPTION0:  opt_next    = cmd_wdata; // RULE_09
            CMD_OTG_VOLT: otgv_next   = cmd_wdata[7:0]; // RULE_03
            CMD_OTG_CUR:  otgc_next   = cmd_wdata[6:0]; // RULE_04
            CMD_IN_VOLT:  inv_next    = cmd_wdata[7:0]; // RULE_05
            CMD_MIN_SYS:  minsys_next = cmd_wdata[5:0]; // RULE_06
            CMD_HOST_LIMIT: iinh_next = cmd_wdata[5:0]; // RULE_07
            default:      opt_next    = opt_reg; // RULE_17
         endcase
      end
   end

   // Conversions freeze while the ADC is off, in low power mode on battery or by adc_cfg_en.
   always_comb begin
      adc_a_next = adc_a_reg;
      adc_b_next = adc_b_reg;
      if (adc_enable) begin
         adc_a_next = {adc_input_current, adc_comparator_input}; // RULE_01
         adc_b_next = {adc_system_voltage, adc_battery_voltage}; // RULE_02
      end
   end

   always_comb begin
      rdv_next = cmd_valid && !cmd_write;
      rd_next  = rd_reg;
      if (cmd_valid && !cmd_write) begin
         case (cmd_code)
            CMD_OPTION0:    rd_next = opt_reg;
            CMD_ADC_IINCMP: rd_next = adc_a_reg; // RULE_01
            CMD_ADC_SYSBAT: rd_next = adc_b_reg; // RULE_02
            CMD_OTG_VOLT:   rd_next = {8'h00, otgv_reg};
            CMD_OTG_CUR:    rd_next = {9'h000, otgc_reg};
            CMD_IN_VOLT:    rd_next = {8'h00, inv_reg};
            CMD_MIN_SYS:    rd_next = {10'h000, minsys_reg};
            CMD_HOST_LIMIT: rd_next = {10'h000, iinh_reg};
            CMD_MAKER_ID:   rd_next = MAKER_ID;
            CMD_PART_ID:    rd_next = PART_ID;
            default:        rd_next = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         opt_reg        <= OPTION0_RESET; // RULE_08
         otgv_reg       <= SETPOINT_RESET[7:0];
         otgc_reg       <= SETPOINT_RESET[6:0];
         inv_reg        <= SETPOINT_RESET[7:0];
         minsys_reg     <= SETPOINT_RESET[5:0];
         iinh_reg       <= SETPOINT_RESET[5:0];
         adc_a_reg      <= 16'h0000;
         adc_b_reg      <= 16'h0000;
         rd_reg         <= 16'h0000;
         rdv_reg        <= 1'b0;
         strap_done_reg <= 1'b0;
      end else begin
         opt_reg        <= opt_next;
         otgv_reg       <= otgv_next;
         otgc_reg       <= otgc_next;
         inv_reg        <= inv_next;
         minsys_reg     <= minsys_next;
         iinh_reg       <= iinh_next;
         adc_a_reg      <= adc_a_next;
         adc_b_reg      <= adc_b_next;
         rd_reg         <= rd_next;
         rdv_reg        <= rdv_next;
         strap_done_reg <= strap_done_next;
      end
   end

   always_comb begin
      if (low_power_active) begin
         prochot_enable    = 1'b0; // RULE_09
         monitor_enable    = 1'b0; // RULE_09
         adc_enable        = 1'b0; // RULE_09
         comparator_enable = cmp_opt_a || cmp_opt_b; // RULE_11
      end else begin
         prochot_enable    = prochot_cfg_en; // RULE_10
         monitor_enable    = monitor_cfg_en; // RULE_10
         adc_enable        = adc_cfg_en; // RULE_10
         comparator_enable = comparator_cfg_en; // RULE_10
      end
   end

   assign charge_current_zero      = wd_expired; // RULE_12
   assign charge_enable            = !wd_expired && charge_values_valid; // RULE_13
   assign rd_data                  = rd_reg;
   assign rd_valid                 = rdv_reg;
   assign otg_voltage              = otgv_reg;
   assign otg_current              = otgc_reg;
   assign input_voltage            = inv_reg;
   assign min_system_voltage       = minsys_reg;
   assign host_input_current_limit = iinh_reg;
   assign charge_option_word_0     = opt_reg;

   AST_OPTION_RESET: assert property ( // RULE_08
      @(posedge clk) $fell(reset) |-> opt_reg == OPTION0_RESET)
      else $error("Option word lacks its reset value.");

   AST_RO_IGNORED: assert property ( // RULE_17
      @(posedge clk) disable iff (reset)
      wr && (cmd_code == CMD_ADC_IINCMP || cmd_code == CMD_MAKER_ID)
      |=> $stable(opt_reg) && $stable(otgv_reg))
      else $error("Write to a read-only word changed a register.");

   AST_RO_SYSBAT: assert property ( // RULE_17
      @(posedge clk) disable iff (reset)
      wr && strap_done_reg
      && (cmd_code == CMD_ADC_SYSBAT || cmd_code == CMD_PART_ID)
      |=> $stable(otgc_reg) && $stable(inv_reg) && $stable(minsys_reg)
      && $stable(iinh_reg))
      else $error("Write to a read-only word changed a setpoint.");

   AST_LOWPWR_OFF: assert property ( // RULE_09
      @(posedge clk) disable iff (reset)
      opt_reg[LWPWR_BIT] && battery_only |-> !adc_enable && !prochot_enable
      && !monitor_enable)
      else $error("Low power mode left a block enabled.");

   AST_LP_CMP_OFF: assert property ( // RULE_09
      @(posedge clk) disable iff (reset)
      low_power_active && !cmp_opt_a && !cmp_opt_b |-> !comparator_enable)
      else $error("Comparator on in low power without its enable bits.");

   AST_ADC_FREEZE: assert property ( // RULE_09
      @(posedge clk) disable iff (reset)
      !adc_enable |=> $stable(adc_a_reg) && $stable(adc_b_reg))
      else $error("Conversion words changed while the ADC was off.");

   AST_CMP_KEEP: assert property ( // RULE_11
      @(posedge clk) disable iff (reset)
      low_power_active && (cmp_opt_a || cmp_opt_b) |-> comparator_enable)
      else $error("Comparator off despite its enable bits.");

   AST_PERF_FOLLOW: assert property ( // RULE_10
      @(posedge clk) disable iff (reset)
      !opt_reg[LWPWR_BIT] |-> adc_enable == adc_cfg_en
      && comparator_enable == comparator_cfg_en)
      else $error("Performance mode ignored its own settings.");

   AST_PERF_BUFFERS: assert property ( // RULE_10
      @(posedge clk) disable iff (reset)
      !opt_reg[LWPWR_BIT] |-> prochot_enable == prochot_cfg_en
      && monitor_enable == monitor_cfg_en)
      else $error("Performance mode ignored its buffer settings.");

   AST_OTG_WRITE: assert property ( // RULE_03
      @(posedge clk) disable iff (reset)
      wr && cmd_code == CMD_OTG_VOLT
      |=> otg_voltage == $past(cmd_wdata[7:0]))
      else $error("OTG voltage write not stored.");

   AST_OTG_CUR_WRITE: assert property ( // RULE_04
      @(posedge clk) disable iff (reset)
      wr && cmd_code == CMD_OTG_CUR
      |=> otg_current == $past(cmd_wdata[6:0]))
      else $error("OTG current write not stored.");

   AST_IN_VOLT_WRITE: assert property ( // RULE_05
      @(posedge clk) disable iff (reset)
      wr && cmd_code == CMD_IN_VOLT
      |=> input_voltage == $past(cmd_wdata[7:0]))
      else $error("Input voltage write not stored.");

   AST_MINSYS_WRITE: assert property ( // RULE_06
      @(posedge clk) disable iff (reset)
      wr && cmd_code == CMD_MIN_SYS
      |=> min_system_voltage == $past(cmd_wdata[5:0]))
      else $error("Minimum system voltage write not stored.");

   AST_HOST_LIMIT_WRITE: assert property ( // RULE_07
      @(posedge clk) disable iff (reset)
      wr && cmd_code == CMD_HOST_LIMIT
      |=> host_input_current_limit == $past(cmd_wdata[5:0]))
      else $error("Host input current limit write not stored.");

   AST_WD_ZERO: assert property ( // RULE_12
      @(posedge clk) disable iff (reset)
      wd_expired |-> charge_current_zero && !charge_enable)
      else $error("Charging not suspended after watchdog expiry.");

   AST_WD_RESTART: assert property ( // RULE_13
      @(posedge clk) disable iff (reset)
      wd_restart |=> !charge_current_zero)
      else $error("Qualifying write left charging suspended.");

   AST_MINSYS_STRAP: assert property ( // RULE_06
      @(posedge clk) $fell(reset) && !wr ##1 !wr
      |=> min_system_voltage == $past(strap_value, 1))
      else $error("Minimum system voltage missed its cell default.");

   AST_ADC_READ: assert property ( // RULE_02
      @(posedge clk) disable iff (reset)
      cmd_valid && !cmd_write && cmd_code == CMD_ADC_SYSBAT
      |=> rd_valid && rd_data == $past(adc_b_reg))
      else $error("Voltage conversion word read wrong.");

   AST_ADC_CUR_READ: assert property ( // RULE_01
      @(posedge clk) disable iff (reset)
      cmd_valid && !cmd_write && cmd_code == CMD_ADC_IINCMP
      |=> rd_valid && rd_data == $past(adc_a_reg))
      else $error("Current conversion word read wrong.");

   AST_ADC_TRACK: assert property ( // RULE_02
      @(posedge clk) disable iff (reset)
      adc_enable |=> adc_b_reg[15:8] == $past(adc_system_voltage)
      && adc_b_reg[7:0] == $past(adc_battery_voltage))
      else $error("Voltage conversion word did not follow the ADC.");
endmodule : cbrw_register_bank

// *** test/cbrw_host_model.sv ***
`timescale 1ns/1ps
module cbrw_host_model (
   input  wire logic        clk,       // Core clock.
   output logic             cmd_valid, // Command strobe.
   output logic             cmd_write, // Write select.
   output logic [7:0]       cmd_code,  // Command code.
   output logic [15:0]      cmd_wdata, // Write word.
   input  wire logic [15:0] rd_data,   // Read word.
   input  wire logic        rd_valid   // Read pulse.
);
   initial begin
      cmd_valid = 1'b0;
      cmd_write = 1'b0;
      cmd_code  = 8'h00;
      cmd_wdata = 16'h0000;
   end

   // Idle code and data are inverted so stale values are never trusted.
   task automatic wr(input logic [7:0] c, input logic [15:0] d);
      @(posedge clk);
      cmd_valid <= 1'b1;
      cmd_write <= 1'b1;
      cmd_code  <= c;
      cmd_wdata <= d;
      @(posedge clk);
      cmd_valid <= 1'b0;
      cmd_code  <= ~c;
      cmd_wdata <= ~d;
   endtask : wr

   task automatic rd(input logic [7:0] c, output logic [15:0] d,
                     output logic v);
      @(posedge clk);
      cmd_valid <= 1'b1;
      cmd_write <= 1'b0;
      cmd_code  <= c;
      @(posedge clk);
      cmd_valid <= 1'b0;
      cmd_code  <= ~c;
      #1;
      v = rd_valid;
      d = rd_data;
   endtask : rd
endmodule : cbrw_host_model

// *** test/testbench.sv ***
`timescale 1ns/1ps
module testbench;
   import cbrw_pkg::*;
   localparam int          TL  = 4;
   localparam logic [15:0] MID = 16'h1357; // Arbitrary value.
   localparam logic [15:0] PID = 16'h2468; // Arbitrary value.
   logic        clk = 1'b0;
   logic        reset = 1'b1;
   logic        cmd_valid, cmd_write, rd_valid;
   logic [7:0]  cmd_code;
   logic [15:0] cmd_wdata, rd_data, option_word;
   logic [1:0]  cell_count = 2'h2;
   logic [7:0]  a_ii = 8'h9C, a_ci = 8'h37, a_sv = 8'hE1, a_bv = 8'h4B;
   logic        battery_only = 1'b0, opt_a = 1'b0, opt_b = 1'b0;
   logic [3:0]  cfg_en = 4'hF;
   logic        values_valid = 1'b1;
   logic [3:0]  en;
   logic        zero, chg_en;
   logic [7:0]  otg_v, in_v;
   logic [6:0]  otg_c;
   logic [5:0]  min_sys, host_lim;
   int          err_count = 0;
   int          n_compared = 0;
   logic [15:0] d;
   logic        v;

   always #2.5 clk = ~clk;

   cbrw_host_model host (.clk(clk), .cmd_valid(cmd_valid),
      .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
      .rd_data(rd_data), .rd_valid(rd_valid));

   cbrw_register_bank #(.TICK_LEN(TL), .T5_TICKS(2), .T88_TICKS(3),
      .T175_TICKS(5), .MAKER_ID(MID), .PART_ID(PID)) DUT (
      .clk(clk), .reset(reset), .cmd_valid(cmd_valid),
      .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
      .rd_data(rd_data), .rd_valid(rd_valid), .cell_count(cell_count),
      .adc_input_current(a_ii), .adc_comparator_input(a_ci),
      .adc_system_voltage(a_sv), .adc_battery_voltage(a_bv),
      .battery_only(battery_only), .cmp_opt_a(opt_a), .cmp_opt_b(opt_b),
      .prochot_cfg_en(cfg_en[3]), .monitor_cfg_en(cfg_en[2]),
      .comparator_cfg_en(cfg_en[1]), .adc_cfg_en(cfg_en[0]),
      .charge_values_valid(values_valid), .prochot_enable(en[3]),
      .monitor_enable(en[2]), .comparator_enable(en[1]),
      .adc_enable(en[0]), .charge_current_zero(zero),
      .charge_enable(chg_en), .otg_voltage(otg_v), .otg_current(otg_c),
      .input_voltage(in_v), .min_system_voltage(min_sys),
      .host_input_current_limit(host_lim),
      .charge_option_word_0(option_word));

   task automatic conclude();
      if (err_count == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : conclude

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask : chk

   task automatic rdchk(input logic [7:0] c, input logic [15:0] exp);
      host.rd(c, d, v);
      chk({15'h0, v}, 16'h0001);
      chk(d, exp);
   endtask : rdchk

   task automatic t_reset();
      rdchk(8'h12, 16'hE20E);
      chk({10'h0, min_sys}, 16'h0024);
      chk(option_word, 16'hE20E);
      rdchk(8'hFE, MID);
      rdchk(8'hFF, PID);
      rdchk(8'h40, 16'h0000);
   endtask : t_reset

   task automatic t_setpoints();
      logic [7:0]  codes [5] = '{8'h3B, 8'h3C, 8'h3D, 8'h3E, 8'h3F};
      logic [15:0] masks [5] = '{16'hFF, 16'h7F, 16'hFF, 16'h3F, 16'h3F};
      for (int i = 0; i < 5; i++) begin
         host.wr(codes[i], 16'hFFFF);
         rdchk(codes[i], masks[i]);
         host.wr(codes[i], 16'hA596 + 16'(i));
         rdchk(codes[i], (16'hA596 + 16'(i)) & masks[i]);
      end
      chk({otg_v, 1'b0, otg_c}, 16'h9617);
      chk({in_v, 2'h0, min_sys}, 16'h9819);
      chk({10'h0, host_lim}, 16'h001A);
   endtask : t_setpoints

   task automatic t_adc();
      rdchk(8'h25, 16'h9C37);
      rdchk(8'h26, 16'hE14B);
      host.wr(8'h25, 16'h0000);
      host.wr(8'hFE, 16'h0000);
      rdchk(8'h25, 16'h9C37);
      rdchk(8'hFE, MID);
   endtask : t_adc

   task automatic t_low_power();
      @(posedge clk);
      battery_only <= 1'b1;
      @(posedge clk);
      #1;
      chk({12'h0, en}, 16'h0000);
      @(posedge clk);
      opt_b <= 1'b1;
      #1;
      chk({12'h0, en}, 16'h0002);
      host.wr(8'h12, 16'h620E);
      cfg_en <= 4'hA;
      @(posedge clk);
      #1;
      chk({12'h0, en}, 16'h000A);
      @(posedge clk);
      cfg_en <= 4'hF;
      opt_b  <= 1'b0;
      battery_only <= 1'b0;
   endtask : t_low_power

   task automatic t_watchdog();
      int n;
      int lim [4] = '{0, 2 * TL, 3 * TL, 5 * TL};
      for (int s = 1; s < 4; s++) begin
         host.wr(8'h12, {1'b0, 2'(s), 13'h020E});
         #1;
         n = 0;
         while (zero !== 1'b1 && n < 300) begin
            @(posedge clk);
            #1;
            n++;
         end
         if (n == 300) begin
            chk(16'h0, 16'h1);
            conclude();
         end
         chk(16'(n), 16'(lim[s]));
         chk({15'h0, chg_en}, 16'h0);
         host.wr(s[0] ? 8'h14 : 8'h15, 16'h0100);
         #1;
         chk({14'h0, zero, chg_en}, 16'h1);
      end
      host.wr(8'h12, 16'h220E);
      repeat (4) begin
         repeat (5) @(posedge clk);
         host.wr(8'h15, 16'h1000);
         #1;
         chk({15'h0, zero}, 16'h0);
      end
      host.wr(8'h12, 16'h020E);
      values_valid <= 1'b0;
      repeat (60) @(posedge clk);
      #1;
      chk({14'h0, zero, chg_en}, 16'h0);
   endtask : t_watchdog

   initial begin
      repeat (20) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      t_reset();
      t_setpoints();
      t_adc();
      t_low_power();
      t_watchdog();
      conclude();
   end
endmodule : testbench
